// File: cpu_init_ctl.sv
// Purpose: processor init sequencer and interrupt pin merge
// Assumes: all link input pins come from outside and are synchronised here
// Notes:   mode data are sampled at the end of each serial clock high
//
// Operation
// R1: OR six interrupt pins into bits 5:0
// R2: OR nonmaskable pin into bit six
// R3: config bit eight zero selects byte-order pin
// R4: ROM-selected ordering needs order pin held low
// R5: agent asserts power-on reset, releases synchronously
// R6: agent asserts reset always, releases synchronously
// R7: cold restart reset may be asynchronous
// R8: reset alone with power-on released: warm restart
// R9: boot clock is system clock over 256
// R10: supply good starts init and mode read
// R11: active-low interrupts synchronised before merging
`timescale 1ns/1ps
module cpu_init_ctl #(
    parameter int unsigned CFG_BITS = init_pkg::BOOT_BITS
) (
    input  wire logic                           clk_sys,
    input  wire logic                           rst_b,
    init_link_if.device                         link,
    input  wire logic [init_pkg::INT_REG_W-1:0] soft_int,
    output logic      [CFG_BITS-1:0]            boot_config,
    output logic                                config_valid,
    output logic                                big_endian,
    output logic                                core_reset,
    output logic                                warm_restart,
    output logic      [init_pkg::INT_REG_W-1:0] int_reg
);
    import init_pkg::*;

    localparam int unsigned CNT_W = $clog2(CFG_BITS);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    // pin synchronisers
    logic [PIN_W-1:0]     pin_meta_r;
    logic [PIN_W-1:0]     pin_s_r;
    logic                 supply_s;
    logic                 por_n_s;
    logic                 rst_n_s;
    logic                 order_s;
    logic [GEN_INT_W-1:0] int_n_s;
    logic                 nmi_n_s;
    logic                 data_s;

    // boot clock divider
    logic [DIV_W-1:0]     div_r;
    logic [DIV_W-1:0]     div_nxt;
    logic                 sclk_r;
    logic                 sclk_nxt;
    logic                 sample_tick;

    // sequencer
    boot_state_t          state_r;
    boot_state_t          state_nxt;
    logic [CNT_W-1:0]     cnt_r;
    logic [CNT_W-1:0]     cnt_nxt;
    logic [CFG_BITS-1:0]  cfg_r;
    logic [CFG_BITS-1:0]  cfg_nxt;
    logic                 valid_r;
    logic                 valid_nxt;
    logic                 warm_r;
    logic                 warm_nxt;
    logic                 hold_r;
    logic                 hold_nxt;
    logic                 endian_r;
    logic                 endian_nxt;

    // interrupt register
    logic [INT_REG_W-1:0] int_r;
    logic [INT_REG_W-1:0] int_nxt;

    ////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers; stage one feeds only stage two, which
    // makes an asynchronous reset edge safe
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pin_meta_r <= PIN_SYNC_RST;
            pin_s_r    <= PIN_SYNC_RST;
        end else begin
            pin_meta_r <= {link.boot_serial_data_in,
                           link.nmi_n,
                           link.int_n,
                           link.byte_order_select,
                           link.reset_n,
                           link.power_on_reset_n,
                           link.supply_good}; // see R11 R7
            pin_s_r    <= pin_meta_r;
        end
    end

    // unpack the synchronised copies
    assign supply_s = pin_s_r[0];
    assign por_n_s  = pin_s_r[1];
    assign rst_n_s  = pin_s_r[2];
    assign order_s  = pin_s_r[3];
    assign int_n_s  = pin_s_r[9:4];
    assign nmi_n_s  = pin_s_r[10];
    assign data_s   = pin_s_r[11];

    ////////////////////////////////////////////////////////////////////////
    // boot clock: low half then high half; restarts from zero with
    // supply_good so the ROM side counts edges from a known start
    always_comb begin
        div_nxt  = DIV_RESET;
        sclk_nxt = 1'b0;
        if (state_r != ST_OFF) begin
            div_nxt  = DIV_W'(div_r + 1'b1); // see R9
            sclk_nxt = div_nxt[DIV_W-1];     // see R9
        end
    end

    // sample at the end of the high half, clear of the ROM's step
    assign sample_tick = (state_r == ST_LOAD) && (div_r == DIV_SAMPLE);

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            div_r  <= DIV_RESET;
            sclk_r <= 1'b0;
        end else begin
            div_r  <= div_nxt;
            sclk_r <= sclk_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // init sequencer: off, load mode bits, hold in reset, run
    always_comb begin
        state_nxt  = state_r;
        cnt_nxt    = cnt_r;
        cfg_nxt    = cfg_r;
        valid_nxt  = valid_r;
        warm_nxt   = warm_r;
        hold_nxt   = 1'b1;
        case (state_r)
            ST_OFF: begin
                valid_nxt = 1'b0;
                warm_nxt  = 1'b0;
                cnt_nxt   = '0;
                if (supply_s) begin
                    state_nxt = ST_LOAD; // see R10
                end
            end
            ST_LOAD: begin
                if (sample_tick) begin
                    cfg_nxt[cnt_r] = data_s; // see R9 R10
                    cnt_nxt        = CNT_W'(cnt_r + 1'b1);
                    if (cnt_r == CNT_W'(CFG_BITS - 1)) begin
                        state_nxt = ST_HOLD;
                        valid_nxt = 1'b1;
                    end
                end
            end
            ST_HOLD: begin
                // leave only once both resets read released
                if (por_n_s && rst_n_s) begin
                    state_nxt = ST_RUN;
                    hold_nxt  = 1'b0;
                end
            end
            ST_RUN: begin
                hold_nxt = 1'b0;
                if (!rst_n_s) begin
                    // reset with power-on still released is a warm one
                    state_nxt = ST_HOLD;          // see R7 R8
                    hold_nxt  = 1'b1;
                    warm_nxt  = por_n_s;          // see R8
                end
            end
            default: begin
                state_nxt = ST_OFF;
            end
        endcase
        // a dropped supply aborts anything, including a load
        if (!supply_s) begin
            state_nxt = ST_OFF;
            hold_nxt  = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_r <= ST_OFF;
            cnt_r   <= '0;
            cfg_r   <= '0;
            valid_r <= 1'b0;
            warm_r  <= 1'b0;
            hold_r  <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            cfg_r   <= cfg_nxt;
            valid_r <= valid_nxt;
            warm_r  <= warm_nxt;
            hold_r  <= hold_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // byte order: config bit set forces big endian; cleared, the pin
    // decides, which is why a ROM-driven system must ground that pin
    always_comb begin
        endian_nxt = order_s; // see R3 R4
        if (valid_r) begin
            endian_nxt = cfg_r[ORDER_CFG_POS] | order_s; // see R3
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            endian_r <= 1'b0;
        end else begin
            endian_r <= endian_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt register: low pin reads as one, ORed with soft_int
    always_comb begin
        int_nxt                  = soft_int;
        int_nxt[GEN_INT_W-1:0]   = soft_int[GEN_INT_W-1:0] | ~int_n_s; // see R1 R11
        int_nxt[NMI_POS]         = soft_int[NMI_POS] | ~nmi_n_s;       // see R2 R11
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            int_r <= '0;
        end else begin
            int_r <= int_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, each straight from a flop
    assign link.boot_serial_clock = sclk_r;
    assign boot_config            = cfg_r;
    assign config_valid           = valid_r;
    assign big_endian             = endian_r;
    assign core_reset             = hold_r;
    assign warm_restart           = warm_r;
    assign int_reg                = int_r;

endmodule : cpu_init_ctl

// File: init_link_chk.sv
// Purpose: assertions on the init link pins and the merged device outputs
// Assumes: one clock, sync active-low rst_b
// Notes:   clock timing by run counters
`timescale 1ns/1ps
module init_link_chk #(
    parameter int unsigned CFG_BITS = 256
) (
    input wire logic                           clk_sys,
    input wire logic                           rst_b,
    input wire logic                           supply_good,
    input wire logic                           power_on_reset_n,
    input wire logic                           reset_n,
    input wire logic                           byte_order_select,
    input wire logic [init_pkg::GEN_INT_W-1:0] int_n,
    input wire logic                           nmi_n,
    input wire logic                           boot_serial_clock,
    input wire logic                           boot_serial_data_in,
    input wire logic [init_pkg::INT_REG_W-1:0] soft_int,
    input wire logic [CFG_BITS-1:0]            boot_config,
    input wire logic                           config_valid,
    input wire logic                           big_endian,
    input wire logic                           core_reset,
    input wire logic                           warm_restart,
    input wire logic [init_pkg::INT_REG_W-1:0] int_reg
);
    import init_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic       bsc_d_r, bsc_d_nxt, seen_r, seen_nxt;
    logic [9:0] run_r, run_nxt, per_r, per_nxt;
    logic       rise;

    // level run length and rise-to-rise distance, saturating
    always_comb begin
        rise      = boot_serial_clock && !bsc_d_r;
        bsc_d_nxt = boot_serial_clock;
        run_nxt   = (boot_serial_clock != bsc_d_r) ? 10'h001 : run_r + 10'(run_r != 10'h3FF);
        per_nxt   = rise ? 10'h001 : per_r + 10'(per_r != 10'h3FF);
        // no period before the first rise
        seen_nxt  = !supply_good ? 1'b0 : (rise ? 1'b1 : seen_r);
    end

    // counter registers only
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            bsc_d_r <= 1'b0;
            seen_r  <= 1'b0;
            run_r   <= 10'h000;
            per_r   <= 10'h000;
        end else begin
            bsc_d_r <= bsc_d_nxt;
            seen_r  <= seen_nxt;
            run_r   <= run_nxt;
            per_r   <= per_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    chk_int_merge: assert property (
        $stable({nmi_n, int_n, soft_int})[*4] |-> int_reg == ({~nmi_n, ~int_n} | soft_int))
        else $error("int merge wrong");
    chk_gen_latency: assert property (
        $changed(int_n) ##1 ($stable(int_n) && soft_int == 7'h00)[*3] |-> int_reg[5:0] == ~int_n)
        else $error("int latency wrong");
    chk_nmi_latency: assert property (
        $fell(nmi_n) ##1 (!nmi_n && !soft_int[NMI_POS])[*3] |-> int_reg[NMI_POS])
        else $error("nmi late");
    chk_nmi_sync: assert property (
        $fell(nmi_n) && $past(nmi_n, 2) && !soft_int[NMI_POS] |=> !int_reg[NMI_POS])
        else $error("nmi not synced");
    chk_order_pin: assert property (
        $stable(byte_order_select)[*4] && (!config_valid || !boot_config[ORDER_CFG_POS])
        && !($past(config_valid) && $past(boot_config[ORDER_CFG_POS]))
        |-> big_endian == byte_order_select)
        else $error("order pin ignored");
    chk_order_rom: assert property (
        config_valid && $past(config_valid) && boot_config[ORDER_CFG_POS] |-> big_endian)
        else $error("order cfg ignored");
    chk_por_holds: assert property (
        !power_on_reset_n[*5] |-> core_reset)
        else $error("por not held");
    chk_reset_holds: assert property (
        !reset_n[*5] |-> core_reset)
        else $error("reset not held");
    chk_warm_entry: assert property (
        (!core_reset && $fell(reset_n) && power_on_reset_n) ##1 power_on_reset_n[*4]
        |-> ##[1:3] (core_reset && warm_restart))
        else $error("warm missed");
    chk_cold_entry: assert property (
        (!core_reset && $fell(reset_n) && !power_on_reset_n) ##1 !power_on_reset_n[*4]
        |-> ##[1:3] (core_reset && !warm_restart))
        else $error("cold as warm");
    chk_clk_high: assert property (
        $fell(boot_serial_clock) && supply_good |-> run_r == 10'd128)
        else $error("sclk high wrong");
    chk_clk_period: assert property (
        rise && seen_r |-> per_r == 10'd256)
        else $error("sclk period wrong");
    chk_supply_start: assert property (
        $rose(supply_good) |-> ##[120:140] $rose(boot_serial_clock))
        else $error("sclk no start");
    chk_supply_off: assert property (
        !supply_good[*6] |-> core_reset && !config_valid && !boot_serial_clock)
        else $error("active unpowered");
endmodule : init_link_chk

// File: init_link_if.sv
// Purpose: pin bundle between the processor init logic and its agent
// Assumes: every pin is a plain one-way wire
// Notes:   active-low pins end in _n
`timescale 1ns/1ps
interface init_link_if;
    logic       supply_good;
    logic       power_on_reset_n;
    logic       reset_n;
    logic       byte_order_select;
    logic [5:0] int_n;
    logic       nmi_n;
    logic       boot_serial_clock;
    logic       boot_serial_data_in;

    modport device (
        input  supply_good, power_on_reset_n, reset_n, byte_order_select,
        input  int_n, nmi_n, boot_serial_data_in,
        output boot_serial_clock
    );

    modport agent (
        output supply_good, power_on_reset_n, reset_n, byte_order_select,
        output int_n, nmi_n, boot_serial_data_in,
        input  boot_serial_clock
    );
endinterface : init_link_if

// File: init_pkg.sv
// Purpose: shared constants and types for the init and interrupt link
// Assumes: one system clock of 20 MHz on both ends
// Notes:   controller register map too
package init_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and boot serial timing
    localparam int unsigned SYS_CLK_HZ   = 20_000_000;
    localparam int unsigned BOOT_CLK_DIV = 256;
    localparam int unsigned DIV_W        = $clog2(BOOT_CLK_DIV);
    localparam int unsigned BOOT_BITS    = 256;
    localparam logic [7:0]  DIV_RESET    = 8'h00;
    localparam logic [7:0]  DIV_SAMPLE   = 8'hFF;

    ////////////////////////////////////////////////////////////////////////
    // interrupt register layout
    localparam int unsigned GEN_INT_W    = 6;
    localparam int unsigned INT_REG_W    = 7;
    localparam int unsigned NMI_POS      = 6;
    localparam int unsigned ORDER_CFG_POS = 8;

    // pin sync vector: {data, nmi, int[5:0], order, reset, por, supply}
    localparam int unsigned PIN_W        = 12;
    localparam logic [11:0] PIN_SYNC_RST = 12'h7F0;

    ////////////////////////////////////////////////////////////////////////
    // controller register map, byte offsets
    localparam int unsigned ADDR_W       = 8;
    localparam logic [7:0]  CTRL_OFS     = 8'h00;
    localparam logic [7:0]  INT_OFS      = 8'h04;
    localparam logic [7:0]  STAT_OFS     = 8'h08;
    localparam logic [7:0]  ROM_OFS      = 8'h40;
    localparam int unsigned CTRL_SUPPLY  = 0;
    localparam int unsigned CTRL_POR     = 1;
    localparam int unsigned CTRL_RST     = 2;
    localparam int unsigned CTRL_ORDER   = 3;
    localparam logic [3:0]  CTRL_RST_VAL = 4'h0;
    localparam logic [6:0]  INT_N_RST    = 7'h7F;
    localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_LOAD,
        ST_HOLD,
        ST_RUN
    } boot_state_t;

endpackage : init_pkg

// File: system_agent.sv
// Purpose: external agent and serial mode ROM, driven over AHB-Lite
// Assumes: zero-wait slave, single word transfers only
// Notes:   ROM image is written by software before supply_good rises
`timescale 1ns/1ps
module system_agent #(
    parameter int unsigned ROM_BITS = init_pkg::BOOT_BITS
) (
    input  wire logic                        clk_sys,
    input  wire logic                        rst_b,
    input  wire logic                        hsel,
    input  wire logic [init_pkg::ADDR_W-1:0] haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic                             hreadyout,
    output logic                             hresp,
    output logic [31:0]                      hrdata,
    init_link_if.agent                       link
);
    import init_pkg::*;

    localparam int unsigned ROM_WORDS = ROM_BITS / 32;
    localparam int unsigned IDX_W     = $clog2(ROM_BITS);

    logic [31:0]       rom_r [ROM_WORDS];
    logic [3:0]        ctrl_r, ctrl_nxt;
    logic [6:0]        int_n_r, int_n_nxt;
    logic              wr_pend_r, wr_pend_nxt;
    logic [ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
    logic [31:0]       hrdata_r, hrdata_nxt;
    logic              sclk_meta_r, sclk_s_r, sclk_d_r;
    logic [IDX_W-1:0]  idx_r, idx_nxt;
    logic              data_r, data_nxt;
    logic              addr_ok;

    // word slot of a ROM address, ROM_WORDS when out of range
    function automatic int unsigned rom_slot(input logic [ADDR_W-1:0] a);
        int unsigned w;
        w = 32'(a >> 2) - 32'(ROM_OFS >> 2);
        if (a < ROM_OFS || w >= ROM_WORDS) begin
            w = ROM_WORDS;
        end
        return w;
    endfunction : rom_slot

    ////////////////////////////////////////////////////////////////////////
    // bus slave: reads answer in the data phase, writes land at its end
    assign addr_ok = hsel && hready && (htrans == HTRANS_NSEQ);

    always_comb begin
        ctrl_nxt    = ctrl_r;
        int_n_nxt   = int_n_r;
        wr_pend_nxt = addr_ok && hwrite;
        wr_addr_nxt = addr_ok ? haddr : wr_addr_r;
        hrdata_nxt  = hrdata_r;
        if (wr_pend_r) begin
            // control and interrupt pins change only here, so every release is clock aligned
            if (wr_addr_r == CTRL_OFS) begin
                ctrl_nxt = hwdata[3:0]; // see R5 R6 R8 R4
            end
            if (wr_addr_r == INT_OFS) begin
                int_n_nxt = ~hwdata[6:0];
            end
        end
        if (addr_ok && !hwrite) begin
            hrdata_nxt = 32'h0000_0000;
            if (haddr == CTRL_OFS) begin
                hrdata_nxt[3:0] = ctrl_r;
            end else if (haddr == INT_OFS) begin
                hrdata_nxt[6:0] = ~int_n_r;
            end else if (haddr == STAT_OFS) begin
                hrdata_nxt[0] = sclk_s_r;
                hrdata_nxt[IDX_W+7:8] = idx_r;
            end else if (rom_slot(haddr) < ROM_WORDS) begin
                hrdata_nxt = rom_r[rom_slot(haddr)];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ctrl_r    <= CTRL_RST_VAL;
            int_n_r   <= INT_N_RST;
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
            hrdata_r  <= 32'h0000_0000;
            hreadyout <= 1'b0;
        end else begin
            ctrl_r    <= ctrl_nxt;
            int_n_r   <= int_n_nxt;
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            hrdata_r  <= hrdata_nxt;
            hreadyout <= 1'b1;
        end
    end

    // ROM is not reset: software loads it first
    always_ff @(posedge clk_sys) begin
        if (wr_pend_r && rom_slot(wr_addr_r) < ROM_WORDS) begin
            rom_r[rom_slot(wr_addr_r)] <= hwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode ROM: next bit after each falling edge of the serial clock
    always_comb begin
        idx_nxt = idx_r;
        if (!ctrl_r[CTRL_SUPPLY]) begin
            idx_nxt = '0;
        end else if (sclk_d_r && !sclk_s_r) begin
            idx_nxt = IDX_W'(idx_r + 1'b1);
        end
        data_nxt = rom_r[idx_r[IDX_W-1:5]][idx_r[4:0]];
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sclk_meta_r <= 1'b0;
            sclk_s_r    <= 1'b0;
            sclk_d_r    <= 1'b0;
            idx_r       <= '0;
            data_r      <= 1'b0;
        end else begin
            sclk_meta_r <= link.boot_serial_clock;
            sclk_s_r    <= sclk_meta_r;
            sclk_d_r    <= sclk_s_r;
            idx_r       <= idx_nxt;
            data_r      <= data_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drive, all straight from flops except hresp, tied low
    assign hresp                    = 1'b0;
    assign hrdata                   = hrdata_r;
    assign link.supply_good         = ctrl_r[CTRL_SUPPLY];
    assign link.power_on_reset_n    = ctrl_r[CTRL_POR];
    assign link.reset_n             = ctrl_r[CTRL_RST];
    assign link.byte_order_select   = ctrl_r[CTRL_ORDER];
    assign link.int_n               = int_n_r[5:0];
    assign link.nmi_n               = int_n_r[6];
    assign link.boot_serial_data_in = data_r;

endmodule : system_agent

// File: tb.sv
// Purpose: self-checking bench for the init sequencer and its agent
// Assumes: agent answers on AHB-Lite, both ends share clk_sys
// Notes:   64 mode bits keep the run short
`timescale 1ns/1ps
module tb;
    import init_pkg::*;
    localparam int unsigned CFG = 64;

    logic              clk_sys = 1'b0;
    logic              rst_b   = 1'b0;
    logic              hsel    = 1'b0;
    logic [7:0]        haddr   = 8'h00;
    logic [1:0]        htrans  = 2'h0;
    logic              hwrite  = 1'b0;
    logic [2:0]        hsize   = 3'h2;
    logic [31:0]       hwdata  = 32'h0;
    logic [6:0]        soft_int = 7'h00;
    logic              hreadyout, hresp, config_valid, big_endian, core_reset, warm_restart;
    logic [31:0]       hrdata;
    logic [CFG-1:0]    boot_config;
    logic [6:0]        int_reg;
    int                errors = 0;
    int                check_count = 0;

    // 20 MHz system clock
    always #25 clk_sys = ~clk_sys;

    init_link_if lnk ();
    cpu_init_ctl #(.CFG_BITS(CFG)) i_cpu_init_ctl (.clk_sys(clk_sys), .rst_b(rst_b),
        .link(lnk.device), .soft_int(soft_int), .boot_config(boot_config),
        .config_valid(config_valid), .big_endian(big_endian), .core_reset(core_reset),
        .warm_restart(warm_restart), .int_reg(int_reg));
    system_agent #(.ROM_BITS(CFG)) i_system_agent (.clk_sys(clk_sys), .rst_b(rst_b),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .link(lnk.agent));
    init_link_chk #(.CFG_BITS(CFG)) i_init_link_chk (.clk_sys(clk_sys), .rst_b(rst_b),
        .supply_good(lnk.supply_good), .power_on_reset_n(lnk.power_on_reset_n),
        .reset_n(lnk.reset_n), .byte_order_select(lnk.byte_order_select),
        .int_n(lnk.int_n), .nmi_n(lnk.nmi_n), .boot_serial_clock(lnk.boot_serial_clock),
        .boot_serial_data_in(lnk.boot_serial_data_in), .soft_int(soft_int),
        .boot_config(boot_config), .config_valid(config_valid), .big_endian(big_endian),
        .core_reset(core_reset), .warm_restart(warm_restart), .int_reg(int_reg));

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    // n edges, then look after the updates
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : settle

    // bounded wait for hready
    task automatic wait_rdy();
        @(posedge clk_sys);
        for (int n = 0; hreadyout !== 1'b1; n++) begin
            if (n > 50) begin
                errors++;
                give_verdict();
            end
            @(posedge clk_sys);
        end
    endtask : wait_rdy

    // single word transfer, driven just after edges
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= HTRANS_NSEQ;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        hsel   <= 1'b0;
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        ahb(1'b1, a, d, rd);
    endtask : wr

    task automatic rd_cmp(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        ahb(1'b0, a, 32'h0, rd);
        cmp(rd, exp);
    endtask : rd_cmp

    // which: 0 config_valid, 1 core_reset; looks 1 ns after each edge
    task automatic wait_flag(input logic which, input logic v, output int n);
        for (n = 0; (which ? core_reset : config_valid) !== v; n++) begin
            if (n > 20000) begin
                errors++;
                give_verdict();
            end
            settle(1);
        end
    endtask : wait_flag

    ////////////////////////////////////////////////////////////////////////
    task automatic s_idle();
        rd_cmp(CTRL_OFS, 32'(CTRL_RST_VAL));
        wr(8'h20, 32'hFFFF_FFFF);
        rd_cmp(8'h20, 32'h0);
        cmp(32'({core_reset, config_valid, lnk.boot_serial_clock}), 32'h4);
    endtask : s_idle

    // each line alone, then pin plus internal source
    task automatic s_ints();
        for (int i = 0; i < INT_REG_W; i++) begin
            wr(INT_OFS, 32'h1 << i);
            settle(2);
            cmp(32'(int_reg), i == 0 ? 32'h0 : 32'h1 << (i - 1));
            settle(1);
            cmp(32'(int_reg), 32'h1 << i);
        end
        wr(INT_OFS, 32'h20);
        soft_int <= 7'h41;
        settle(4);
        cmp(32'(int_reg), 32'h61);
        soft_int <= 7'h00;
        wr(INT_OFS, 32'h0);
        settle(4);
        cmp(32'(int_reg), 32'h0);
    endtask : s_ints

    // load the mode data, then release both resets
    task automatic s_boot(input logic [31:0] w0, input logic [31:0] w1, input logic ord,
                          input logic exp_big);
        int n;
        wr(ROM_OFS, w0);
        wr(ROM_OFS + 8'h04, w1);
        wr(CTRL_OFS, {28'h0, ord, 3'b001});
        wait_flag(1'b0, 1'b1, n);
        cmp(32'(n >= CFG * BOOT_CLK_DIV && n <= CFG * BOOT_CLK_DIV + 10), 32'h1);
        cmp(boot_config[31:0], w0);
        cmp(boot_config[63:32], w1);
        settle(1);
        cmp(32'({big_endian, core_reset}), {30'h0, exp_big, 1'b1});
        wr(CTRL_OFS, {28'h0, ord, 3'b111});
        wait_flag(1'b1, 1'b0, n);
    endtask : s_boot

    task automatic s_restart();
        int n;
        wr(CTRL_OFS, 32'h3);
        settle(6);
        cmp(32'({core_reset, warm_restart}), 32'h3);
        wr(CTRL_OFS, 32'h7);
        wait_flag(1'b1, 1'b0, n);
        wr(CTRL_OFS, 32'h1);
        settle(6);
        cmp(32'({core_reset, warm_restart}), 32'h2);
        wr(CTRL_OFS, 32'h5);
        settle(6);
        cmp(32'(core_reset), 32'h1);
        wr(CTRL_OFS, 32'h7);
        wait_flag(1'b1, 1'b0, n);
        wr(CTRL_OFS, 32'h0);
        settle(8);
        cmp(32'({core_reset, config_valid}), 32'h2);
    endtask : s_restart

    ////////////////////////////////////////////////////////////////////////
    // order pin low while the stored ordering rules
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        s_idle();
        s_ints();
        s_boot(32'hA5C3_01F1, 32'h8000_0001, 1'b0, 1'b1);
        s_restart();
        s_boot(32'h5A3C_FE0E, 32'h7FFF_FFFE, 1'b1, 1'b1);
        wr(CTRL_OFS, 32'h7);
        settle(5);
        cmp(32'(big_endian), 32'h0);
        give_verdict();
    end
endmodule : tb
